// ### src/dvmh_core.sv
// Functional notes
// - Mute pin output flags 1024 zero samples
// - Decode on: zero run asserts pin, soft-mutes
// - Decode off: high on pin soft-mutes
// - Decode disable is bit 6, address 0x0C
// - Left attenuation 8 bits, resets 0xFF
// - Right attenuation 8 bits, resets 0xFF
// - Master attenuation sets every channel at once
// - Update clear only loads the intermediate latch
// - Update set moves all latches to active
// - Code 0 mutes, then 0.5dB steps
// - Write to 0x1F restores all register defaults
// - Reset state held until next write completes
// - DC-blocking highpass on each ADC channel
// - Filter band edges kept by surrounding filters
// - Highpass disable bit 3 bypasses filter
`timescale 1ns/100ps
`default_nettype none
module dvmh_core (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ctl_sclk,
  input  wire logic        ctl_sdin,
  input  wire logic        ctl_latch,
  input  wire logic        dac_in_valid,
  input  wire logic [23:0] dac_in_data,
  input  wire logic        dac_in_right,
  output logic             dac_in_ready,
  output logic             dac_out_valid,
  output logic      [23:0] dac_out_data,
  output logic             dac_out_right,
  input  wire logic        dac_out_ready,
  input  wire logic        adc_in_valid,
  input  wire logic [23:0] adc_in_data,
  input  wire logic        adc_in_right,
  output logic             adc_out_valid,
  output logic      [23:0] adc_out_data,
  output logic             adc_out_right,
  input  wire logic        mute_in,
  output logic             mute_out,
  output logic             mute_oe
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       sclk_d1_q;
  logic       latch_d1_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q    <= 4'h0;
      sync2_q    <= 4'h0;
      sclk_d1_q  <= 1'b0;
      latch_d1_q <= 1'b0;
    end else begin
      sync1_q    <= {mute_in, ctl_latch, ctl_sdin, ctl_sclk};
      sync2_q    <= sync1_q;
      sclk_d1_q  <= sync2_q[0];
      latch_d1_q <= sync2_q[2];
    end
  end

  // ****************************************
  // Serial control port
  // ****************************************
  logic [15:0] shift_q;
  logic        wr;
  logic [6:0]  wr_addr;
  logic [8:0]  wr_data;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_q <= 16'h0000;
    end else if (sync2_q[0] && !sclk_d1_q) begin
      shift_q <= {shift_q[14:0], sync2_q[1]};
    end
  end

  assign wr      = sync2_q[2] && !latch_d1_q;
  assign wr_addr = shift_q[15:9];
  assign wr_data = shift_q[8:0];

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] lat_q [2];
  logic [7:0] act_q [2];
  logic [7:0] nlat  [2];
  logic [8:0] adcctl_q;
  logic       hold_q;
  logic       is_att;
  logic       mute_decode_disable;
  logic       hpd;

  assign is_att = (wr_addr == dvmh_pkg::ADDR_LEFT) || (wr_addr == dvmh_pkg::ADDR_RIGHT)
                  || (wr_addr == dvmh_pkg::ADDR_MASTER);
  assign mute_decode_disable    = adcctl_q[dvmh_pkg::BIT_MPD];
  assign hpd    = adcctl_q[dvmh_pkg::BIT_HPD];

  always_comb begin
    nlat[0] = lat_q[0];
    nlat[1] = lat_q[1];
    if (wr_addr == dvmh_pkg::ADDR_LEFT) begin
      nlat[0] = wr_data[7:0];
    end else if (wr_addr == dvmh_pkg::ADDR_RIGHT) begin
      nlat[1] = wr_data[7:0];
    end else if (wr_addr == dvmh_pkg::ADDR_MASTER) begin
      nlat[0] = wr_data[7:0];
      nlat[1] = wr_data[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || (wr && wr_addr == dvmh_pkg::ADDR_SWRST)) begin
      lat_q[0] <= dvmh_pkg::ATTEN_RST;
      lat_q[1] <= dvmh_pkg::ATTEN_RST;
      act_q[0] <= dvmh_pkg::ATTEN_RST;
      act_q[1] <= dvmh_pkg::ATTEN_RST;
      adcctl_q <= dvmh_pkg::ADCCTL_RST;
    end else if (wr) begin
      if (is_att) begin
        lat_q[0] <= nlat[0];
        lat_q[1] <= nlat[1];
        if (wr_data[dvmh_pkg::BIT_UPDATE]) begin
          act_q[0] <= nlat[0];
          act_q[1] <= nlat[1];
        end
      end else if (wr_addr == dvmh_pkg::ADDR_ADCCTL) begin
        adcctl_q <= wr_data;
      end
    end
  end

  // Held state mutes and blanks both paths
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_q <= 1'b0;
    end else if (wr) begin
      hold_q <= (wr_addr == dvmh_pkg::ADDR_SWRST);
    end
  end

  // ****************************************
  // Zero run detect and soft-mute
  // ****************************************
  logic        fifo_valid;
  logic [24:0] fifo_data;
  logic        take;
  logic [10:0] zcnt_q;
  logic        soft_mute_q;
  logic        run_full;

  assign run_full = (zcnt_q == dvmh_pkg::ZERO_RUN);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      zcnt_q <= 11'h000;
    end else if (take) begin
      if (fifo_data[23:0] != 24'h00_0000) begin
        zcnt_q <= 11'h000;
      end else if (!run_full) begin
        zcnt_q <= zcnt_q + 11'h001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      soft_mute_q <= 1'b0;
      mute_out    <= 1'b0;
      mute_oe     <= 1'b1;
    end else begin
      soft_mute_q <= mute_decode_disable ? sync2_q[3] : run_full;
      mute_out    <= !mute_decode_disable && run_full;
      mute_oe     <= !mute_decode_disable;
    end
  end

  // ****************************************
  // Gain ramp
  // ****************************************
  logic [7:0] tick_q;
  logic       tick;
  logic [7:0] ramp_q [2];

  assign tick = (tick_q == dvmh_pkg::RAMP_LAST);

  always_ff @(posedge core_clk) begin
    if (rst || tick) begin
      tick_q <= 8'h00;
    end else begin
      tick_q <= tick_q + 8'h01;
    end
  end

  // One half-dB step per tick avoids zipper noise
  for (genvar i = 0; i < 2; i++) begin : g_ramp
    logic [7:0] tgt;
    assign tgt = (soft_mute_q || hold_q) ? 8'h00 : act_q[i];
    always_ff @(posedge core_clk) begin
      if (rst) begin
        ramp_q[i] <= dvmh_pkg::ATTEN_RST;
      end else if (tick && ramp_q[i] < tgt) begin
        ramp_q[i] <= ramp_q[i] + 8'h01;
      end else if (tick && ramp_q[i] > tgt) begin
        ramp_q[i] <= ramp_q[i] - 8'h01;
      end
    end
  end

  // ****************************************
  // DAC sample path
  // ****************************************
  dvmh_fifo #(
    .WIDTH (dvmh_pkg::FIFO_W),
    .DEPTH (dvmh_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst       (rst),
    .in_valid  (dac_in_valid),
    .in_data   ({dac_in_right, dac_in_data}),
    .in_ready  (dac_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (take)
  );

  assign take = fifo_valid && (!dac_out_valid || dac_out_ready);

  logic [7:0]         code;
  logic [7:0]         att;
  logic [7:0]         quo;
  logic [7:0]         rem;
  logic signed [40:0] prod;
  logic signed [40:0] scaled;
  logic [5:0]         sh;
  logic [23:0]        gained;

  always_comb begin
    code   = ramp_q[fifo_data[24]];
    att    = dvmh_pkg::ATTEN_RST - code;
    quo    = att / dvmh_pkg::STEPS_6DB;
    rem    = att % dvmh_pkg::STEPS_6DB;
    prod   = $signed(fifo_data[23:0]) * $signed({1'b0, dvmh_pkg::mant(rem[3:0])});
    sh     = 6'h10 + {1'b0, quo[4:0]};
    scaled = prod >>> sh;
    gained = (code == 8'h00) ? 24'h00_0000 : scaled[23:0];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dac_out_valid <= 1'b0;
      dac_out_data  <= 24'h00_0000;
      dac_out_right <= 1'b0;
    end else if (take) begin
      dac_out_valid <= 1'b1;
      dac_out_data  <= gained;
      dac_out_right <= fifo_data[24];
    end else if (dac_out_ready) begin
      dac_out_valid <= 1'b0;
    end
  end

  // ****************************************
  // ADC highpass
  // ****************************************
  logic [23:0]             xp_q [2];
  logic signed [25:0]      yp_q [2];
  logic signed [25:0]      y;
  logic [23:0]             ysat;
  logic                    ach;

  // Pole at 1 - 2^-11, within 0.002% of 0.9995
  always_comb begin
    ach = adc_in_right;
    y   = $signed({{2{adc_in_data[23]}}, adc_in_data})
          - $signed({{2{xp_q[ach][23]}}, xp_q[ach]})
          + yp_q[ach] - (yp_q[ach] >>> dvmh_pkg::HPF_SHIFT);
    if (y > $signed(26'h07F_FFFF)) begin
      ysat = 24'h7F_FFFF;
    end else if (y < $signed(26'h3F8_0000)) begin
      ysat = 24'h80_0000;
    end else begin
      ysat = y[23:0];
    end
  end

  // Band edges belong to the decimator; corner here sits far below them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      xp_q[0]       <= 24'h00_0000;
      xp_q[1]       <= 24'h00_0000;
      yp_q[0]       <= 26'sh000_0000;
      yp_q[1]       <= 26'sh000_0000;
      adc_out_valid <= 1'b0;
      adc_out_data  <= 24'h00_0000;
      adc_out_right <= 1'b0;
    end else begin
      adc_out_valid <= adc_in_valid;
      if (adc_in_valid) begin
        xp_q[ach]     <= adc_in_data;
        yp_q[ach]     <= hpd ? 26'sh000_0000 : y;
        adc_out_right <= ach;
        if (hold_q) begin
          adc_out_data <= 24'h00_0000;
        end else begin
          adc_out_data <= hpd ? adc_in_data : ysat;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_MUTE_FLAG: assert property (!mute_decode_disable && run_full |=> mute_out && mute_oe)
    else $error("mute pin not flagged after zero run");
  AST_DECODE_MUTE: assert property (!mute_decode_disable && run_full |=> soft_mute_q)
    else $error("zero run did not soft-mute");
  AST_PIN_MUTE: assert property (mute_decode_disable && sync2_q[3] |=> soft_mute_q && !mute_oe)
    else $error("pin input did not soft-mute");
  AST_LATCH_ONLY: assert property (wr && is_att && !wr_data[8] && !hold_q
    |=> act_q[0] == $past(act_q[0]) && act_q[1] == $past(act_q[1]))
    else $error("active attenuation changed without update");
  AST_UPDATE: assert property (wr && is_att && wr_data[8]
    |=> act_q[0] == lat_q[0] && act_q[1] == lat_q[1])
    else $error("update did not apply latches");
  AST_MASTER: assert property (wr && wr_addr == 7'h08 |=> lat_q[0] == lat_q[1])
    else $error("master write did not reach both latches");
  AST_SWRST: assert property (wr && wr_addr == 7'h1F
    |=> hold_q && lat_q[1] == 8'hFF && adcctl_q == 9'h000)
    else $error("software reset did not restore defaults");
  AST_HOLD: assert property (hold_q && !wr |=> hold_q)
    else $error("held state released without write");
  AST_RAMP: assert property (ramp_q[0] != $past(ramp_q[0])
    |-> $past(tick) && (ramp_q[0] - $past(ramp_q[0]) == 8'h01
        || $past(ramp_q[0]) - ramp_q[0] == 8'h01))
    else $error("gain ramp jumped");
  AST_MUTE_CODE: assert property (take && code == 8'h00 |=> dac_out_data == 24'h00_0000)
    else $error("code zero did not mute");
  AST_BYPASS: assert property (adc_in_valid && hpd && !hold_q
    |=> adc_out_data == $past(adc_in_data))
    else $error("highpass not bypassed");

  COV_UPDATE: cover property (wr && is_att && wr_data[8]);
  COV_SWRST: cover property (hold_q ##1 !hold_q);
  COV_ZERO_RUN: cover property (!mute_decode_disable ##0 run_full ##1 mute_out);

endmodule
`default_nettype wire

// ### src/dvmh_pkg.sv
package dvmh_pkg;

  // ****************************************
  // Control word layout
  // ****************************************
  localparam int         ADDR_W      = 7;
  localparam int         DATA_W      = 9;
  localparam int         WORD_W      = 16;
  localparam logic [6:0] ADDR_LEFT   = 7'h00;
  localparam logic [6:0] ADDR_RIGHT  = 7'h01;
  localparam logic [6:0] ADDR_MASTER = 7'h08;
  localparam logic [6:0] ADDR_ADCCTL = 7'h0C;
  localparam logic [6:0] ADDR_SWRST  = 7'h1F;
  localparam int         BIT_UPDATE  = 8;
  localparam int         BIT_HPD     = 3;
  localparam int         BIT_MPD     = 6;
  localparam logic [7:0] ATTEN_RST   = 8'hFF;
  localparam logic [8:0] ADCCTL_RST  = 9'h000;

  // ****************************************
  // Datapath
  // ****************************************
  localparam int          SAMPLE_W   = 24;
  localparam int          ACC_W      = 26;
  localparam logic [10:0] ZERO_RUN   = 11'h400;
  localparam int          HPF_SHIFT  = 11;
  localparam logic [7:0]  STEPS_6DB  = 8'h0C;
  localparam int          FIFO_DEPTH = 8;
  localparam int          FIFO_W     = SAMPLE_W + 1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_MHZ      = 200;
  localparam int         RAMP_STEP_NS = 640;
  localparam int         RAMP_CYCLES  = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] RAMP_LAST    = 8'(RAMP_CYCLES - 1);

  // Gain for 0..11 half-dB steps, unsigned 0.16
  function automatic logic [15:0] mant(input logic [3:0] r);
    case (r)
      4'h0:    mant = 16'hFFFF;
      4'h1:    mant = 16'hF1AE;
      4'h2:    mant = 16'hE429;
      4'h3:    mant = 16'hD766;
      4'h4:    mant = 16'hCB59;
      4'h5:    mant = 16'hBFF9;
      4'h6:    mant = 16'hB53C;
      4'h7:    mant = 16'hAB19;
      4'h8:    mant = 16'hA186;
      4'h9:    mant = 16'h987D;
      4'hA:    mant = 16'h8FF6;
      default: mant = 16'h87E8;
    endcase
  endfunction

endpackage

// ### src/dvmh_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module dvmh_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wptr_q;
  logic [PW-1:0]    rptr_q;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  logic             push;
  logic             pop;

  assign push = in_valid && in_ready;
  // Read data always leaves through the output register
  assign pop  = (!out_valid || out_ready) && (cnt_q != '0);

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_q   <= '0;
      rptr_q   <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == PW'(DEPTH - 1)) ? '0 : wptr_q + PW'(1);
      end
      if (pop) begin
        rptr_q <= (rptr_q == PW'(DEPTH - 1)) ? '0 : rptr_q + PW'(1);
      end
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != CW'(DEPTH));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem_q[rptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### bench/dvmh_host.sv
`timescale 1ns/100ps
`default_nettype none
module dvmh_host (
  input  wire logic        core_clk,
  output logic             ctl_sclk,
  output logic             ctl_sdin,
  output logic             ctl_latch,
  output logic             dac_in_valid,
  output logic      [23:0] dac_in_data,
  output logic             dac_in_right,
  input  wire logic        dac_in_ready
);
  initial begin
    ctl_sclk     = 1'b0;
    ctl_sdin     = 1'b0;
    ctl_latch    = 1'b0;
    dac_in_valid = 1'b0;
    dac_in_data  = 24'h00_0000;
    dac_in_right = 1'b0;
  end

  // ****************************************
  // Control port
  // ****************************************
  // Pins cross two sync stages, so each level stands 3 cycles
  task automatic wr(input logic [6:0] addr, input logic [8:0] data);
    logic [15:0] w;
    w = {addr, data};
    for (int i = 15; i >= 0; i--) begin
      @(posedge core_clk);
      ctl_sdin <= w[i];
      repeat (3) @(posedge core_clk);
      ctl_sclk <= 1'b1;
      repeat (3) @(posedge core_clk);
      ctl_sclk <= 1'b0;
    end
    repeat (3) @(posedge core_clk);
    ctl_latch <= 1'b1;
    repeat (3) @(posedge core_clk);
    ctl_latch <= 1'b0;
    repeat (8) @(posedge core_clk);
    ctl_sdin <= ~w[0];
  endtask

  // ****************************************
  // Sample stream
  // ****************************************
  // Gives up after 20 cycles so a full buffer shows as a refusal
  task automatic push(input logic r, input logic [23:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge core_clk);
    dac_in_valid <= 1'b1;
    dac_in_data  <= d;
    dac_in_right <= r;
    do begin
      @(posedge core_clk);
      n++;
    end while (dac_in_ready !== 1'b1 && n < 20);
    ok = (dac_in_ready === 1'b1);
    dac_in_valid <= 1'b0;
    dac_in_data  <= ~d;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_dvmh_core.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dvmh_core;
  logic        core_clk;
  logic        rst;
  logic        ctl_sclk;
  logic        ctl_sdin;
  logic        ctl_latch;
  logic        dac_in_valid;
  logic [23:0] dac_in_data;
  logic        dac_in_right;
  logic        dac_in_ready;
  logic        dac_out_valid;
  logic [23:0] dac_out_data;
  logic        dac_out_right;
  logic        adc_out_right;
  logic        dac_out_ready;
  logic        adc_in_valid;
  logic [23:0] adc_in_data;
  logic        adc_in_right;
  logic        adc_out_valid;
  logic [23:0] adc_out_data;
  logic        mute_in;
  logic        mute_out;
  logic        mute_oe;
  logic        mute_drv;
  logic [23:0] v;
  logic        ok;
  logic [23:0] out_q[$];
  int          error_cnt;
  int          comparisons;
  int          cyc;
  int          n;

  // Shared mute pin level
  assign mute_in = mute_oe ? mute_out : mute_drv;

  dvmh_core DUT (
    .core_clk     (core_clk),
    .rst          (rst),
    .ctl_sclk     (ctl_sclk),
    .ctl_sdin     (ctl_sdin),
    .ctl_latch    (ctl_latch),
    .dac_in_valid (dac_in_valid),
    .dac_in_data  (dac_in_data),
    .dac_in_right (dac_in_right),
    .dac_in_ready (dac_in_ready),
    .dac_out_valid(dac_out_valid),
    .dac_out_data (dac_out_data),
    .dac_out_right(dac_out_right),
    .dac_out_ready(dac_out_ready),
    .adc_in_valid (adc_in_valid),
    .adc_in_data  (adc_in_data),
    .adc_in_right (adc_in_right),
    .adc_out_valid(adc_out_valid),
    .adc_out_data (adc_out_data),
    .adc_out_right(adc_out_right),
    .mute_in      (mute_in),
    .mute_out     (mute_out),
    .mute_oe      (mute_oe)
  );

  dvmh_host host (
    .core_clk    (core_clk),
    .ctl_sclk    (ctl_sclk),
    .ctl_sdin    (ctl_sdin),
    .ctl_latch   (ctl_latch),
    .dac_in_valid(dac_in_valid),
    .dac_in_data (dac_in_data),
    .dac_in_right(dac_in_right),
    .dac_in_ready(dac_in_ready)
  );

  // ****************************************
  // Clock, monitor, timeout
  // ****************************************
  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (rst === 1'b0 && dac_out_valid === 1'b1 && dac_out_ready === 1'b1) begin
      out_q.push_back(dac_out_data);
    end
  end

  // Longest wait is the ramp to mute, about 30k cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic dac_get(input logic r, input logic [23:0] d, output logic [23:0] y);
    int k;
    logic o;
    k = 0;
    out_q.delete();
    host.push(r, d, o);
    while (out_q.size() == 0 && k < 50) begin
      @(posedge core_clk);
      k++;
    end
    y = (out_q.size() > 0) ? out_q[0] : {24{1'bx}};
  endtask

  task automatic adc(input logic r, input logic [23:0] x, output logic [23:0] y);
    @(posedge core_clk);
    adc_in_valid <= 1'b1;
    adc_in_data  <= x;
    adc_in_right <= r;
    @(posedge core_clk);
    adc_in_valid <= 1'b0;
    adc_in_data  <= ~x;
    #1;
    y = (adc_out_valid === 1'b1) ? adc_out_data : {24{1'bx}};
  endtask

  task automatic finish_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    core_clk      = 1'b0;
    rst           = 1'b1;
    dac_out_ready = 1'b1;
    adc_in_valid  = 1'b0;
    adc_in_data   = 24'h00_0000;
    adc_in_right  = 1'b0;
    mute_drv      = 1'b0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({23'h0, mute_oe}, 24'h00_0001);
    chk({23'h0, mute_out}, 24'h00_0000);
    repeat (4) @(posedge core_clk);
    dac_get(1'b0, 24'h01_0000, v);
    chk(v, 24'h00_FFFF);
    dac_get(1'b1, 24'h01_0000, v);
    chk(v, 24'h00_FFFF);
    chk({23'h0, dac_out_right}, 24'h00_0001);
    // Latch only, then a right write with update moves both
    host.wr(dvmh_pkg::ADDR_LEFT, 9'h0F3);
    repeat (2000) @(posedge core_clk);
    dac_get(1'b0, 24'h01_0000, v);
    chk(v, 24'h00_FFFF);
    host.wr(dvmh_pkg::ADDR_RIGHT, 9'h1F3);
    repeat (1700) @(posedge core_clk);
    dac_get(1'b0, 24'h01_0000, v);
    chk(v, 24'h00_7FFF);
    dac_get(1'b1, 24'h01_0000, v);
    chk(v, 24'h00_7FFF);
    host.wr(dvmh_pkg::ADDR_MASTER, 9'h1E7);
    repeat (1700) @(posedge core_clk);
    dac_get(1'b0, 24'h01_0000, v);
    chk(v, 24'h00_3FFF);
    dac_get(1'b1, 24'h01_0000, v);
    chk(v, 24'h00_3FFF);
    // Pin as input: high level soft-mutes, gain must fall gradually
    host.wr(dvmh_pkg::ADDR_ADCCTL, 9'h040);
    chk({23'h0, mute_oe}, 24'h00_0000);
    mute_drv <= 1'b1;
    repeat (300) @(posedge core_clk);
    dac_get(1'b0, 24'h01_0000, v);
    chk({23'h0, v != 24'h00_0000 && v < 24'h00_3FFF}, 24'h00_0001);
    repeat (30000) @(posedge core_clk);
    dac_get(1'b0, 24'h01_0000, v);
    chk(v, 24'h00_0000);
    mute_drv <= 1'b0;
    // Highpass: step input, per channel state, then bypass
    adc(1'b0, 24'h10_0000, v);
    chk(v, 24'h10_0000);
    adc(1'b0, 24'h10_0000, v);
    chk(v, 24'h0F_FE00);
    adc(1'b1, 24'h10_0000, v);
    chk(v, 24'h10_0000);
    chk({23'h0, adc_out_right}, 24'h00_0001);
    host.wr(dvmh_pkg::ADDR_ADCCTL, 9'h048);
    adc(1'b0, 24'h12_3456, v);
    chk(v, 24'h12_3456);
    // Software reset, hold, release by the next write
    host.wr(dvmh_pkg::ADDR_SWRST, 9'h000);
    chk({23'h0, mute_oe}, 24'h00_0001);
    adc(1'b0, 24'h10_0000, v);
    chk(v, 24'h00_0000);
    host.wr(dvmh_pkg::ADDR_ADCCTL, 9'h008);
    adc(1'b0, 24'h12_3456, v);
    chk(v, 24'h12_3456);
    // Zero run; the first zeros also fill the buffer until refused
    dac_out_ready <= 1'b0;
    n = 0;
    for (int i = 0; i < 12; i++) begin
      host.push(1'b0, 24'h00_0000, ok);
      n += int'(ok);
    end
    chk(24'(n), 24'h00_000A);
    dac_out_ready <= 1'b1;
    for (int i = 0; i < 1013; i++) begin
      host.push(i[0], 24'h00_0000, ok);
    end
    repeat (10) @(posedge core_clk);
    chk({23'h0, mute_out}, 24'h00_0000);
    host.push(1'b1, 24'h00_0000, ok);
    repeat (10) @(posedge core_clk);
    chk({23'h0, mute_out}, 24'h00_0001);
    chk({23'h0, mute_oe}, 24'h00_0001);
    host.push(1'b0, 24'h01_0000, ok);
    repeat (10) @(posedge core_clk);
    chk({23'h0, mute_out}, 24'h00_0000);
    finish_test();
  end
endmodule
`default_nettype wire
